// File: logic/pfst_pkg.sv
// package for the piezo force sense trigger block: offsets, fields, timing
// Contract
// [RULE1] monitor enable set: both differential outputs released, actuator floats
// [RULE2] sensing runs only while output enable is set
// [RULE3] while sensing is active, waveform output is suppressed
// [RULE4] host sets monitor enable only when playback idle reads one
// [RULE5] sensed value register refreshed with every new sample while sensing
// [RULE6] sensed value is 12-bit two's complement, zero means zero volts
// [RULE7] sensed value register carries a sensing-active read-back bit
// [RULE8] crossing held for hold time sets the detection flag
// [RULE9] writing comparator enable to zero clears the detection flag
// [RULE10] comparison and detection happen only while comparator enable is one
// [RULE11] direction bit: zero detects above threshold, one detects below
// [RULE12] 3-bit hold-time code sets hold time; code five is 2048 us
// [RULE13] 12-bit trip level sets the differential trip voltage
// [RULE14] pin function six drives detection on gpio; five uses interrupt path
// [RULE15] triggered playback enabled and detection: start armed waveform
// [RULE16] host re-arms a waveform after every automatic playback
// [RULE17] monitor enable clears itself on automatic playback
// [RULE18] triggered-playback enable clears itself on automatic playback
// [RULE19] host toggles comparator enable zero then one before next trigger
// [RULE20] playback idle status shows waveform playback has finished
// [RULE21] sensing may start after playback by setting monitor enable alone
// [RULE22] host leaves sensing by soft reset
// [RULE23] hold counter restarts when voltage returns before hold time elapses
// [RULE24] all control enables accepted in one register write
package pfst_pkg;
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] sense_cfg_off = 8'h04;
   localparam logic [7:0] sense_val_off = 8'h08;
   localparam logic [7:0] status_off = 8'h0c;
   localparam logic [7:0] pin_cfg_off = 8'h10;
   // control register fields
   localparam int ctrl_oe_bit = 0;
   localparam int ctrl_sense_bit = 1;
   localparam int ctrl_comp_bit = 2;
   localparam int ctrl_auto_bit = 3;
   localparam int ctrl_rst_bit = 4;
   // sensing config fields
   localparam int cfg_level_lsb = 0;
   localparam int cfg_hold_lsb = 12;
   localparam int cfg_dir_bit = 15;
   // sensed value and status fields
   localparam int val_flag_bit = 12;
   localparam int val_active_bit = 13;
   localparam int status_idle_bit = 0;
   localparam logic [31:0] ctrl_rst_val = 32'h0000_0000;
   localparam logic [31:0] cfg_rst_val = 32'h0000_0000;
   localparam logic [2:0] pin_rst_val = 3'h0;
   localparam logic [2:0] pin_sel_irq = 3'h5;
   localparam logic [2:0] pin_sel_detect = 3'h6;
   // hold time base: 64 us per unit, code n -> 64 us << n (code 5 = 2048 us)
   localparam int hold_base_us = 64;
   localparam int clk_mhz = 100;
   localparam int hold_base_cyc = hold_base_us * clk_mhz;
   localparam int tick_us = 1;
   localparam int tick_cyc = tick_us * clk_mhz;
endpackage

// File: logic/pfst_hold_timer.sv
// hold-time timer: counts microsecond ticks while the crossing persists
`timescale 1ns/1ps
`default_nettype none
module pfst_hold_timer #(
   parameter int cnt_w = 14
)
(
   input wire logic sys_clk, // core clock
   input wire logic nrst, // async reset, active low
   input wire logic tick, // one-cycle microsecond enable
   input wire logic beyond, // sample lies past threshold
   input wire logic [cnt_w-1:0] limit, // ticks to hold
   output logic done // hold satisfied, level
);
   logic [cnt_w-1:0] cnt_r;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         cnt_r <= '0;
      else if (!beyond)
         cnt_r <= '0; // RULE23
      else if (tick && cnt_r != limit)
         cnt_r <= cnt_r + 1'b1;
   end

   assign done = beyond && (cnt_r == limit);

   a_hold_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
      !beyond |=> cnt_r == '0) // RULE23
      else $error("hold counter did not restart");
endmodule // pfst_hold_timer
`default_nettype wire

// File: logic/pfst_top.sv
// piezo force sense trigger: axi4-lite registers, comparator, auto playback launch
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pfst_top (
   input wire logic sys_clk, // 100 mhz core clock
   input wire logic nrst, // async reset, active low
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [11:0] adc_sample, // sensed differential voltage, async
   input wire logic adc_valid, // new sample strobe level toggle, async
   input wire logic play_idle_in, // playback engine idle, same clock
   output logic drive_en, // output stage allowed to drive out+/out-
   output logic hv_meas_en, // high-voltage node measurement enable
   output logic wave_en, // waveform output permitted
   output logic sense_mode, // actuator monitor mode active
   output logic auto_start, // one-cycle pulse launching armed waveform
   output logic gpio_out, // gpio notification level
   output logic irq_event, // detection routed to interrupt path
   output logic soft_rst // one-cycle soft reset request
);
   logic oe_r, sense_r, comp_r, auto_r, dir_r;
   logic [11:0] level_r;
   logic [2:0] hold_r;
   logic [2:0] pin_r;
   logic flag_r;
   logic [11:0] val_r;
   logic [11:0] samp_s1_r, samp_s2_r;
   logic tog_s1_r, tog_s2_r, tog_s3_r;
   logic idle_r;
   logic [6:0] tick_cnt_r;
   logic tick_r;
   logic aw_hold_r, w_hold_r;
   logic [31:0] awaddr_r, wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go, fire, beyond, hold_done, active;
   logic [13:0] hold_limit;

   assign active = sense_r && oe_r; // RULE2

   // write channel: address and data taken in either order, then one response
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 32'h0000_0000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_hold_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         else if (wr_go)
            w_hold_r <= 1'b0;
      end
   end

   assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r[7:0] == pfst_pkg::ctrl_off ||
               awaddr_r[7:0] == pfst_pkg::sense_cfg_off ||
               awaddr_r[7:0] == pfst_pkg::pin_cfg_off ||
               awaddr_r[7:0] == pfst_pkg::sense_val_off ||
               awaddr_r[7:0] == pfst_pkg::status_off) ? 2'h0 : 2'h2;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // control bits; one write carries every enable at once
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         oe_r <= pfst_pkg::ctrl_rst_val[pfst_pkg::ctrl_oe_bit];
         sense_r <= pfst_pkg::ctrl_rst_val[pfst_pkg::ctrl_sense_bit];
         comp_r <= pfst_pkg::ctrl_rst_val[pfst_pkg::ctrl_comp_bit];
         auto_r <= pfst_pkg::ctrl_rst_val[pfst_pkg::ctrl_auto_bit];
         soft_rst <= 1'b0;
      end
      else if (soft_rst)
      begin
         // soft reset returns controls to defaults
         oe_r <= 1'b0;
         sense_r <= 1'b0;
         comp_r <= 1'b0;
         auto_r <= 1'b0;
         soft_rst <= 1'b0;
      end
      else
      begin
         soft_rst <= 1'b0;
         if (wr_go && awaddr_r[7:0] == pfst_pkg::ctrl_off && wstrb_r[0])
         begin
            oe_r <= wdata_r[pfst_pkg::ctrl_oe_bit]; // RULE24
            sense_r <= wdata_r[pfst_pkg::ctrl_sense_bit]; // RULE21
            comp_r <= wdata_r[pfst_pkg::ctrl_comp_bit];
            auto_r <= wdata_r[pfst_pkg::ctrl_auto_bit];
            soft_rst <= wdata_r[pfst_pkg::ctrl_rst_bit];
         end
         // the launch wins over a concurrent write so a trigger never re-arms itself
         if (fire)
         begin
            sense_r <= 1'b0; // RULE17
            auto_r <= 1'b0; // RULE18
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         level_r <= pfst_pkg::cfg_rst_val[11:0];
         hold_r <= pfst_pkg::cfg_rst_val[14:12];
         dir_r <= pfst_pkg::cfg_rst_val[15];
         pin_r <= pfst_pkg::pin_rst_val;
      end
      else if (soft_rst)
      begin
         level_r <= pfst_pkg::cfg_rst_val[11:0];
         hold_r <= pfst_pkg::cfg_rst_val[14:12];
         dir_r <= pfst_pkg::cfg_rst_val[15];
         pin_r <= pfst_pkg::pin_rst_val;
      end
      else if (wr_go && awaddr_r[7:0] == pfst_pkg::sense_cfg_off)
      begin
         if (wstrb_r[0])
            level_r[7:0] <= wdata_r[7:0];
         if (wstrb_r[1])
         begin
            level_r[11:8] <= wdata_r[11:8]; // RULE13
            hold_r <= wdata_r[pfst_pkg::cfg_hold_lsb +: 3]; // RULE12
            dir_r <= wdata_r[pfst_pkg::cfg_dir_bit]; // RULE11
         end
      end
      else if (wr_go && awaddr_r[7:0] == pfst_pkg::pin_cfg_off && wstrb_r[0])
         pin_r <= wdata_r[2:0];
   end

   // sample path: data sync'd two deep, captured on toggle of the sync'd strobe
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         samp_s1_r <= 12'h000;
         samp_s2_r <= 12'h000;
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
         val_r <= 12'h000;
         idle_r <= 1'b1;
      end
      else
      begin
         samp_s1_r <= adc_sample;
         samp_s2_r <= samp_s1_r;
         tog_s1_r <= adc_valid;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
         idle_r <= play_idle_in; // RULE20
         // data settles before the strobe toggles, so the sync'd copy is stable here
         if (active && tog_s2_r != tog_s3_r)
            val_r <= samp_s2_r; // RULE5 RULE6
      end
   end

   // microsecond tick divider
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tick_cnt_r <= 7'h00;
         tick_r <= 1'b0;
      end
      else if (tick_cnt_r == 7'(pfst_pkg::tick_cyc - 1))
      begin
         tick_cnt_r <= 7'h00;
         tick_r <= 1'b1;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 7'h01;
         tick_r <= 1'b0;
      end
   end

   assign beyond = active && comp_r && // RULE10
      (dir_r ? ($signed(val_r) < $signed(level_r))
             : ($signed(val_r) > $signed(level_r))); // RULE11
   // code n holds 64 us << n; code 5 gives 2048 us
   assign hold_limit = 14'(pfst_pkg::hold_base_us) << hold_r; // RULE12

   pfst_hold_timer #(
      .cnt_w(14)
   ) u_hold (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .tick(tick_r),
      .beyond(beyond),
      .limit(hold_limit),
      .done(hold_done)
   );

   // detection flag: cleared by soft reset or while comparator enable is zero
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         flag_r <= 1'b0;
      else if (soft_rst)
         flag_r <= 1'b0;
      else if (hold_done)
         flag_r <= 1'b1; // RULE8
      else if (!comp_r)
         flag_r <= 1'b0; // RULE9
   end

   assign fire = hold_done && !flag_r && auto_r; // RULE15

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         drive_en <= 1'b0;
         hv_meas_en <= 1'b0;
         wave_en <= 1'b0;
         sense_mode <= 1'b0;
         auto_start <= 1'b0;
         gpio_out <= 1'b0;
         irq_event <= 1'b0;
      end
      else
      begin
         drive_en <= oe_r && !sense_r; // RULE1
         hv_meas_en <= oe_r; // RULE2
         wave_en <= oe_r && !active; // RULE3
         sense_mode <= active;
         auto_start <= fire; // RULE15
         gpio_out <= (pin_r == pfst_pkg::pin_sel_detect) && flag_r; // RULE14
         irq_event <= (pin_r == pfst_pkg::pin_sel_irq) && hold_done && !flag_r; // RULE14
      end
   end

   // read channel: one cycle after address, held until rready
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr[7:0])
               pfst_pkg::ctrl_off:
                  s_axi_rdata <= {28'h0, auto_r, comp_r, sense_r, oe_r};
               pfst_pkg::sense_cfg_off:
                  s_axi_rdata <= {16'h0, dir_r, hold_r, level_r};
               pfst_pkg::sense_val_off:
                  s_axi_rdata <= {18'h0, active, flag_r, val_r}; // RULE7
               pfst_pkg::status_off:
                  s_axi_rdata <= {31'h0, idle_r}; // RULE20
               pfst_pkg::pin_cfg_off:
                  s_axi_rdata <= {29'h0, pin_r};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   a_sense_floats: assert property (@(posedge sys_clk) disable iff (!nrst)
      sense_r |=> !drive_en) // RULE1
      else $error("output driven while monitoring");
   a_sense_needs_oe: assert property (@(posedge sys_clk) disable iff (!nrst)
      !oe_r |=> !sense_mode) // RULE2
      else $error("sensing without output enable");
   a_wave_muted: assert property (@(posedge sys_clk) disable iff (!nrst)
      sense_mode |-> !wave_en) // RULE3
      else $error("waveform while sensing");
   a_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
      hold_done && !soft_rst |=> flag_r) // RULE8
      else $error("detection flag not set");
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
      !comp_r && !hold_done |=> !flag_r) // RULE9
      else $error("flag survived comparator off");
   a_comp_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
      !comp_r |-> !beyond) // RULE10
      else $error("compare while comparator off");
   a_auto_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
      fire |=> !auto_r && !sense_r ##0 auto_start) // RULE17 RULE18
      else $error("self-clear or launch missing");
   a_gpio_route: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(flag_r) && pin_r == pfst_pkg::pin_sel_detect && $stable(pin_r) |=> gpio_out) // RULE14
      else $error("gpio missed detection");
   c_launch: cover property (@(posedge sys_clk) disable iff (!nrst) auto_start);
   c_flag: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(flag_r));
   c_sample: cover property (@(posedge sys_clk) disable iff (!nrst) sense_mode && $changed(val_r));
endmodule // pfst_top
`default_nettype wire

// File: verification/pfst_far_model.sv
// far-side model: actuator sense path and waveform playback engine
`timescale 1ns/1ps
`default_nettype none
module pfst_far_model #(
   parameter int play_len = 2000
)
(
   input wire logic sys_clk, // core clock
   input wire logic auto_start, // launch pulse from the block
   output logic [11:0] adc_sample, // sensed differential voltage
   output logic adc_valid, // toggles once per new sample
   output logic play_idle_in // playback engine idle level
);
   logic armed_r;
   int play_cnt;
   initial
   begin
      adc_sample = 12'h000;
      adc_valid = 1'b0;
      play_idle_in = 1'b1;
      armed_r = 1'b0;
      play_cnt = 0;
   end
   // word settles several clocks before the toggle, then the synchroniser gets time
   task automatic push(input logic [11:0] v);
      adc_sample <= v;
      repeat (4) @(posedge sys_clk);
      adc_valid <= ~adc_valid;
      repeat (12) @(posedge sys_clk);
   endtask
   task automatic arm();
      armed_r <= 1'b1;
   endtask
   // an unarmed waveform never plays, so a missing re-arm shows as no idle drop
   always @(posedge sys_clk)
   begin
      if (auto_start === 1'b1 && armed_r)
      begin
         armed_r <= 1'b0;
         play_cnt <= play_len;
         play_idle_in <= 1'b0;
      end
      else if (play_cnt > 1)
         play_cnt <= play_cnt - 1;
      else if (play_cnt == 1)
      begin
         play_cnt <= 0;
         play_idle_in <= 1'b1;
      end
   end
endmodule // pfst_far_model
`default_nettype wire

// File: verification/tb.sv
// testbench for the piezo force sense trigger block
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] wr; logic [1:0] rr;} pfst_row_t;
   localparam logic [31:0] a_ctrl = {24'h0, pfst_pkg::ctrl_off};
   localparam logic [31:0] a_cfg = {24'h0, pfst_pkg::sense_cfg_off};
   localparam logic [31:0] a_val = {24'h0, pfst_pkg::sense_val_off};
   localparam logic [31:0] a_stat = {24'h0, pfst_pkg::status_off};
   localparam logic [31:0] a_pin = {24'h0, pfst_pkg::pin_cfg_off};
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [11:0] adc_sample;
   logic adc_valid, play_idle_in, drive_en, hv_meas_en, wave_en, sense_mode;
   logic auto_start, gpio_out, irq_event, soft_rst;
   logic [31:0] q;
   int err_total = 0, n_tests = 0, irq_cnt = 0, auto_cnt = 0, soft_cnt = 0, n;
   pfst_row_t rows[6] = '{
      '{a_cfg, 32'h0000_8abc, 32'h0000_8abc, 2'h0, 2'h0},
      '{a_cfg, 32'h0000_7001, 32'h0000_7001, 2'h0, 2'h0},
      '{a_pin, 32'h0000_0006, 32'h0000_0006, 2'h0, 2'h0},
      '{a_pin, 32'h0000_0005, 32'h0000_0005, 2'h0, 2'h0},
      '{a_stat, 32'h0000_0000, 32'h0000_0001, 2'h0, 2'h0},
      '{32'h0000_0014, 32'h0000_0001, 32'h0000_0000, 2'h2, 2'h2}};
   always #5 sys_clk = ~sys_clk;
   pfst_top pfst_top_inst (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_sample, .adc_valid, .play_idle_in,
      .drive_en, .hv_meas_en, .wave_en, .sense_mode, .auto_start, .gpio_out, .irq_event,
      .soft_rst);
   pfst_far_model pfst_far_model_inst (.sys_clk, .auto_start, .adc_sample, .adc_valid,
      .play_idle_in);
   always @(posedge sys_clk)
   begin
      irq_cnt <= irq_cnt + (irq_event === 1'b1);
      auto_cnt <= auto_cnt + (auto_start === 1'b1);
      soft_cnt <= soft_cnt + (soft_rst === 1'b1);
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
      int k;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         k++;
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && k < 60);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (k >= 60)
         err_total++;
      @(posedge sys_clk);
   endtask
   task automatic w(input logic [31:0] a, input logic [31:0] d);
      logic [1:0] rs;
      wr(a, d, rs);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] dq, output logic [1:0] rs);
      int k;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         k++;
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && k < 60);
      dq = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (k >= 60)
         err_total++;
      @(posedge sys_clk);
   endtask
   task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] dq;
      logic [1:0] rs;
      rd(a, dq, rs);
      chk(nm, dq, exp);
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      cyc(90000);
      err_total++;
      test_done();
   end
   initial
   begin
      s_axi_awaddr <= 32'h0000_0000;
      s_axi_wdata <= 32'h0000_0000;
      s_axi_araddr <= 32'h0000_0000;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      cyc(6);
      nrst <= 1'b1;
      cyc(2);
      chk("outs", {drive_en, wave_en, sense_mode, auto_start, gpio_out}, 32'h0);
      rc("ctrl", a_ctrl, 32'h0);
      rc("cfg", a_cfg, 32'h0);
      rc("pin", a_pin, 32'h0);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d, r);
         chk("bresp", r, rows[i].wr);
         rd(rows[i].a, q, r);
         chk("rdata", q, rows[i].q);
         chk("rresp", r, rows[i].rr);
      end
      // byte lanes: lane 0 alone moves only the low level bits, lane 1 alone misses ctrl
      s_axi_wstrb <= 4'h1;
      w(a_cfg, 32'h0000_8abc);
      s_axi_wstrb <= 4'h2;
      w(a_ctrl, 32'h0000_0003);
      s_axi_wstrb <= 4'hf;
      rc("strb", a_cfg, 32'h0000_70bc);
      rc("strb", a_ctrl, 32'h0000_0000);
      // plain sensing, no comparator
      w(a_ctrl, 32'h3);
      pfst_far_model_inst.push(12'h123);
      chk("mon", {sense_mode, drive_en, wave_en, hv_meas_en}, 32'h9);
      rc("val", a_val, 32'h0000_2123);
      pfst_far_model_inst.push(12'hf80);
      rc("val", a_val, 32'h0000_2f80);
      // rising detection; an early return restarts the hold count
      w(a_pin, 32'h6);
      w(a_cfg, 32'h0000_0100);
      w(a_ctrl, 32'h7);
      pfst_far_model_inst.push(12'h200);
      cyc(4000);
      pfst_far_model_inst.push(12'h050);
      pfst_far_model_inst.push(12'h200);
      cyc(4000);
      rc("val", a_val, 32'h0000_2200);
      chk("gpio", gpio_out, 32'h0);
      cyc(3000);
      rc("val", a_val, 32'h0000_3200);
      chk("gpio", gpio_out, 32'h1);
      w(a_ctrl, 32'h3);
      rc("val", a_val, 32'h0000_2200);
      chk("gpio", gpio_out, 32'h0);
      cyc(7000);
      rc("val", a_val, 32'h0000_2200);
      // falling detection routed to the interrupt path
      w(a_pin, 32'h5);
      w(a_cfg, 32'h0000_8000);
      pfst_far_model_inst.push(12'h050);
      w(a_ctrl, 32'h7);
      pfst_far_model_inst.push(12'hf00);
      cyc(7000);
      rc("val", a_val, 32'h0000_3f00);
      chk("irq", irq_cnt, 32'h1);
      chk("gpio", gpio_out, 32'h0);
      // automatic playback launch
      w(a_ctrl, 32'h3);
      w(a_pin, 32'h6);
      w(a_cfg, 32'h0000_0100);
      pfst_far_model_inst.push(12'h050);
      pfst_far_model_inst.arm();
      w(a_ctrl, 32'hf);
      pfst_far_model_inst.push(12'h200);
      n = 0;
      while (auto_cnt == 0 && n < 8000)
      begin
         @(posedge sys_clk);
         n++;
      end
      rc("stat", a_stat, 32'h0);
      rc("ctrl", a_ctrl, 32'h5);
      chk("auto", auto_cnt, 32'h1);
      chk("mon", {sense_mode, wave_en}, 32'h1);
      cyc(2100);
      rc("stat", a_stat, 32'h1);
      w(a_ctrl, 32'h7);
      chk("mon", {sense_mode, drive_en, hv_meas_en}, 32'h5);
      w(a_ctrl, 32'h2);
      chk("mon", {sense_mode, hv_meas_en}, 32'h0);
      rc("val", a_val, 32'h0000_0200);
      // soft reset returns the ctrl, cfg and pin registers to their defaults
      w(a_cfg, 32'h0000_0123);
      w(a_ctrl, 32'h10);
      cyc(3);
      chk("srst", soft_cnt, 32'h1);
      rc("ctrl", a_ctrl, 32'h0);
      rc("cfg", a_cfg, 32'h0);
      rc("pin", a_pin, 32'h0);
      test_done();
   end
endmodule // tb
`default_nettype wire
